//--- common/sba_pkg.sv
// Purpose: shared constants and types for the secondary bus arbiter,
//          clock fan-out and secondary reset block
// Assumes: AHB-Lite register access, 32-bit words, one aligned word per register
// Notes:   all offsets are byte addresses
package sba_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int NUM_EXT_REQ = 4;
    localparam int NUM_ARB_REQ = 5;              // four pins plus the bridge
    localparam int NUM_SCLK    = 5;
    localparam int BRIDGE_IDX  = 4;
    localparam int LOW_SLOT    = 5;              // low group token in the top ring

    ////////////////////////////////////////////////////////////////////////////
    // timing: pci clocks up to 33 MHz, sampled by a 250 MHz core clock
    localparam int PCI_CLK_MAX_MHZ  = 33;
    localparam int CORE_CLK_MHZ     = 250;
    localparam int PCI_HALF_CYC_MIN = CORE_CLK_MHZ / (2 * PCI_CLK_MAX_MHZ);
    localparam logic [2:0] STRAP_WAIT = 3'h3;    // sync pipeline fill before straps are caught

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] PRIO_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;

    // control register fields
    localparam int CTRL_SEC_RST  = 0;
    localparam int CTRL_CHIP_RST = 1;
    localparam int CTRL_D3HOT    = 2;
    localparam int CTRL_CLKDIS_LO = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_01f7;
    // priority register: bit n set puts requester n (4 = bridge) in the high group
    localparam logic [31:0] PRIO_RST   = 32'h0000_001f;
    localparam logic [31:0] PRIO_WMASK = 32'h0000_001f;

    // synchroniser reset values: {s_clk, p_clk, bpcc, cfn_n, irdy_n, frame_n, req_n[3:0]}
    localparam logic [9:0] SYNC_RST = 10'h03f;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        ST_HOLD = 2'b01,
        ST_RUN  = 2'b10
    } sba_state_t;

    typedef struct packed {
        logic [4:0] grant;
        logic       sec_rst_on;
        logic       b2;
        logic       int_arb;
        logic       bpcc;
        logic       bus_idle;
    } sba_status_t;

endpackage

//--- hdl/sba_top.sv
// Purpose: secondary bus arbiter, secondary clock fan-out and secondary reset
// Assumes: straps and pci pins are asynchronous to clk; bridge_req is on clk
// Notes:   registers over AHB-Lite, zero wait states, always OKAY
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
module sba_top
    import sba_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    // ahb-lite slave
    input  wire logic                   hsel,
    input  wire logic [7:0]             haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic [31:0]                 hrdata,
    output logic                        hresp,
    // secondary pci pins
    input  wire logic [NUM_EXT_REQ-1:0] s_req_n,
    output logic [NUM_EXT_REQ-1:0]      s_gnt_n,
    output logic [NUM_EXT_REQ-1:0]      s_gnt_oe_n,
    input  wire logic                   s_frame_n,
    input  wire logic                   s_irdy_n,
    input  wire logic                   s_cfn_n,
    input  wire logic                   bpcc,
    input  wire logic                   p_clk_in,
    input  wire logic                   s_clk_in,
    output logic [NUM_SCLK-1:0]         s_clk_out,
    output logic                        s_rst_n,
    output logic                        s_ctl_float,
    output logic                        s_adp_zero,
    output logic                        p_out_float,
    // bridge core side
    input  wire logic                   bridge_req,
    output logic                        bridge_gnt,
    output logic                        bridge_park
);

    ////////////////////////////////////////////////////////////////////////////
    // round-robin pick over a six-slot ring, starting after the last winner
    function automatic logic [2:0] rr_pick(input logic [5:0] m, input logic [2:0] last);
        logic [2:0] pick;
        int         idx;
        pick = last;
        for (int k = 6; k >= 1; k--) begin
            idx = (int'(last) + k) % 6;
            if (m[idx]) begin
                pick = 3'(idx);
            end
        end
        return pick;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    logic       pclk_s;
    logic       sclk_s;
    logic       sclk_old_q;
    logic       sclk_rise;
    logic       bus_idle;
    logic [3:0] req_s;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
        end else begin
            sync1_q <= {s_clk_in, p_clk_in, bpcc, s_cfn_n, s_irdy_n, s_frame_n, s_req_n};
            sync2_q <= sync1_q;
        end
    end

    assign req_s    = sync2_q[3:0];
    assign bus_idle = sync2_q[4] & sync2_q[5];
    assign pclk_s   = sync2_q[8];
    assign sclk_s   = sync2_q[9];

    // s_clk is the returned fan-out clock; only its rising edges step the arbiter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_old_q <= 1'b0;
        end else begin
            sclk_old_q <= sclk_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_old_q;

    ////////////////////////////////////////////////////////////////////////////
    // strap capture after reset release
    sba_state_t st_q;
    logic [2:0] wait_q;
    logic       int_arb_q;
    logic       bpcc_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q      <= ST_HOLD;
            wait_q    <= 3'h0;
            int_arb_q <= 1'b0;
            bpcc_q    <= 1'b0;
        end else begin
            unique case (st_q)
                ST_HOLD: begin
                    wait_q <= wait_q + 3'h1;
                    if (wait_q == STRAP_WAIT) begin
                        int_arb_q <= ~sync2_q[6];
                        bpcc_q    <= sync2_q[7];
                        st_q      <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    st_q <= ST_RUN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers; only the primary reset clears them
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] prio_q;
    logic [31:0] prio_d;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic        acc;
    sba_status_t status;
    logic [31:0] rd_val;

    assign acc = hsel & htrans[1] & hready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= acc & hwrite;
            if (acc) begin
                wr_addr_q <= haddr;
            end
        end
    end

    always_comb begin
        ctrl_d = ctrl_q;
        prio_d = prio_q;
        if (wr_pend_q && wr_addr_q == CTRL_OFS) begin
            ctrl_d = hwdata & CTRL_WMASK;
        end
        if (wr_pend_q && wr_addr_q == PRIO_OFS) begin
            prio_d = hwdata & PRIO_WMASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
            prio_q <= PRIO_RST;
        end else begin
            ctrl_q <= ctrl_d;
            prio_q <= prio_d;
        end
    end

    // reads see a write still in its data phase, so back-to-back access is safe
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (haddr)
            CTRL_OFS:   rd_val = ctrl_d;
            PRIO_OFS:   rd_val = prio_d;
            STATUS_OFS: rd_val = {22'h00_0000, status};
            default:    rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (acc && !hwrite) begin
                hrdata <= rd_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // secondary reset
    logic sec_rst_req;
    assign sec_rst_req = ctrl_q[CTRL_SEC_RST] | ctrl_q[CTRL_CHIP_RST];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_rst_n     <= 1'b0;
            s_ctl_float <= 1'b1;
            s_adp_zero  <= 1'b1;
            p_out_float <= 1'b1;
        end else begin
            s_rst_n     <= ~sec_rst_req;
            s_ctl_float <= sec_rst_req;
            s_adp_zero  <= sec_rst_req;
            p_out_float <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // secondary clock fan-out
    logic b2;
    assign b2 = bpcc_q & ctrl_q[CTRL_D3HOT];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_clk_out <= '0;
        end else begin
            for (int i = 0; i < NUM_SCLK; i++) begin
                s_clk_out[i] <= pclk_s & ~ctrl_q[CTRL_CLKDIS_LO+i] & ~b2;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-level rotating arbiter
    logic [4:0] req_v;
    logic [4:0] hi_m;
    logic [4:0] lo_m;
    logic [2:0] top_pick;
    logic [2:0] lo_pick;
    logic [2:0] winner;
    logic       any_req;
    logic [4:0] gnt_q;
    logic [2:0] owner_q;
    logic [2:0] hi_last_q;
    logic [2:0] lo_last_q;
    logic       rearb;
    logic       run_ok;

    // taken from the reset request, not s_rst_n, so the grant pins float on the
    // same edge that secondary reset goes low instead of one edge later
    assign run_ok = (st_q == ST_RUN) & ~sec_rst_req;
    // in external mode request pin 0 is the bridge's grant, not a master
    assign req_v  = {bridge_req, ~req_s[3:1], ~req_s[0] & int_arb_q};
    assign hi_m   = req_v & prio_q[4:0];
    assign lo_m   = req_v & ~prio_q[4:0];
    assign any_req = |req_v;
    assign top_pick = rr_pick({|lo_m, hi_m}, hi_last_q);
    assign lo_pick  = rr_pick({1'b0, lo_m}, lo_last_q);
    assign winner   = (top_pick == 3'(LOW_SLOT)) ? lo_pick : top_pick;
    // a new owner only on an idle bus or once the holder drops its request
    assign rearb = sclk_rise & (bus_idle | ~req_v[owner_q]);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gnt_q     <= '0;
            owner_q   <= 3'(BRIDGE_IDX);
            hi_last_q <= 3'(LOW_SLOT);
            lo_last_q <= 3'(BRIDGE_IDX);
        end else if (!run_ok || !int_arb_q) begin
            gnt_q   <= '0;
            owner_q <= 3'(BRIDGE_IDX);
        end else if (rearb) begin
            if (any_req) begin
                gnt_q   <= 5'(1) << winner;
                owner_q <= winner;
                if (top_pick == 3'(LOW_SLOT)) begin
                    hi_last_q <= 3'(LOW_SLOT);
                    lo_last_q <= lo_pick;
                end else begin
                    hi_last_q <= top_pick;
                end
            end else begin
                // nobody asks: park the bus on the bridge itself
                gnt_q   <= 5'(1) << BRIDGE_IDX;
                owner_q <= 3'(BRIDGE_IDX);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin and bridge outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_gnt_n     <= '1;
            s_gnt_oe_n  <= '1;
            bridge_gnt  <= 1'b0;
            bridge_park <= 1'b0;
        end else if (!run_ok) begin
            s_gnt_n     <= '1;
            s_gnt_oe_n  <= '1;
            bridge_gnt  <= 1'b0;
            bridge_park <= 1'b0;
        end else if (int_arb_q) begin
            s_gnt_n     <= ~gnt_q[3:0];
            s_gnt_oe_n  <= '0;
            bridge_gnt  <= gnt_q[BRIDGE_IDX] & bus_idle;
            bridge_park <= gnt_q[BRIDGE_IDX] & bus_idle & ~bridge_req;
        end else begin
            s_gnt_n     <= {3'h7, ~bridge_req};
            s_gnt_oe_n  <= 4'he;
            bridge_gnt  <= ~req_s[0] & bus_idle;
            bridge_park <= ~req_s[0] & bus_idle & ~bridge_req;
        end
    end

    assign status = '{grant: gnt_q, sec_rst_on: ~s_rst_n, b2: b2, int_arb: int_arb_q,
                      bpcc: bpcc_q, bus_idle: bus_idle};

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    one_grant_a: assert property ($onehot0(~s_gnt_n & ~s_gnt_oe_n))
        else $error("more than one secondary grant driven");
    sec_rst_set_a: assert property (sec_rst_req |=> !s_rst_n && s_ctl_float)
        else $error("secondary reset not asserted for a set reset bit");
    sec_rst_clear_a: assert property (!sec_rst_req |=> s_rst_n)
        else $error("secondary reset held with both bits clear");
    float_zero_a: assert property (!s_rst_n |-> s_ctl_float && s_adp_zero && (&s_gnt_oe_n))
        else $error("secondary pins not floated during secondary reset");
    regs_kept_a: assert property (!s_rst_n && !wr_pend_q |=> $stable(ctrl_q) && $stable(prio_q))
        else $error("register changed by secondary reset alone");
    b2_stop_a: assert property (b2 |=> s_clk_out == '0)
        else $error("clock output running in b2");
    clk_dis_a: assert property ((s_clk_out & $past(ctrl_q[8:4])) == '0)
        else $error("disabled clock output toggling");
    clk_run_a: assert property (!bpcc_q && ctrl_q[CTRL_D3HOT] && !ctrl_q[CTRL_CLKDIS_LO] && pclk_s
                                |=> s_clk_out[0])
        else $error("clock output stopped in D3hot with strap low");
    ext_req_a: assert property (run_ok && !int_arb_q |=> s_gnt_n[0] == !$past(bridge_req))
        else $error("external request output does not follow bridge request");
    ext_park_a: assert property (run_ok && !int_arb_q && !req_s[0] && bus_idle && !bridge_req
                                 |=> bridge_park && bridge_gnt)
        else $error("bridge did not park under external grant");
    strap_fixed_a: assert property (st_q == ST_RUN && $past(st_q) == ST_RUN
                                    |-> $stable(int_arb_q))
        else $error("arbiter mode changed after strap capture");

    grant_pin_c: cover property (run_ok && int_arb_q && s_gnt_n != 4'hf);
    low_group_c: cover property (rearb && top_pick == 3'(LOW_SLOT) && any_req);
    park_c:      cover property (bridge_park);
    b2_c:        cover property (b2 ##1 !b2);

endmodule

//--- tb/sba_partner.sv
// Purpose: secondary masters, pci clock source and external arbiter grant
// Assumes: pci clock runs free near 31 MHz; frame and irdy are pulled up
// Notes:   a granted master runs one short burst each time the bus is idle
`timescale 1ns/1ns
module sba_partner
    import sba_pkg::*;
(
    input  wire logic [NUM_EXT_REQ-1:0] want,
    input  wire logic                   ext_arb,
    input  wire logic [NUM_EXT_REQ-1:0] gnt_w,
    input  wire logic                   s_clk_in,
    output logic [NUM_EXT_REQ-1:0]      s_req_n,
    output logic                        s_frame_n,
    output logic                        s_irdy_n,
    output logic                        p_clk_in
);
    logic [2:0] left_q;
    logic       idle;

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        p_clk_in = 1'b0;
        forever #16 p_clk_in = ~p_clk_in;
    end

    // in external mode bit 0 is the grant to the bridge, not a master
    assign s_req_n = ~want;
    assign idle    = s_frame_n & s_irdy_n;

    initial begin
        s_frame_n = 1'b1;
        s_irdy_n  = 1'b1;
        left_q    = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // start only with a grant on an idle bus; release goes to the pull-up level
    always @(posedge s_clk_in) begin
        if (left_q != 3'h0) begin
            left_q <= left_q - 3'h1;
            if (left_q == 3'h2) s_frame_n <= 1'b1;
            if (left_q == 3'h1) s_irdy_n <= 1'b1;
        end else if (idle && |(want & ~gnt_w & {3'h7, ~ext_arb})) begin
            s_frame_n <= 1'b0;
            s_irdy_n  <= 1'b0;
            left_q    <= 3'h4;
        end
    end
endmodule

//--- tb/tb_top.sv
// Purpose: self-checking bench for arbiter, clock fan-out and secondary reset
// Assumes: zero wait state register slave; straps change only across a reset
// Notes:   s_clk_out[0] is fed back as s_clk_in, so its clock-disable bit is never set here
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
    import sba_pkg::*;
    logic                   clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0]             haddr;
    logic [1:0]             htrans;
    logic [2:0]             hsize;
    logic [31:0]            hwdata, hrdata, rdv;
    logic [NUM_EXT_REQ-1:0] s_req_n, s_gnt_n, s_gnt_oe_n, gnt_w, want, gnt_seen;
    logic                   s_frame_n, s_irdy_n, s_cfn_n, bpcc, p_clk_in, ext_arb;
    logic [NUM_SCLK-1:0]    s_clk_out;
    logic                   s_rst_n, s_ctl_float, s_adp_zero, p_out_float;
    logic                   bridge_req, bridge_gnt, bridge_park;
    int                     checks, n_mismatch, gnt_log[$];

    // floated grant pins read high through the board pull-ups
    assign gnt_w  = s_gnt_n | s_gnt_oe_n;
    assign hready = hreadyout;

    sba_top dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .s_req_n(s_req_n),
        .s_gnt_n(s_gnt_n), .s_gnt_oe_n(s_gnt_oe_n), .s_frame_n(s_frame_n),
        .s_irdy_n(s_irdy_n), .s_cfn_n(s_cfn_n), .bpcc(bpcc), .p_clk_in(p_clk_in),
        .s_clk_in(s_clk_out[0]), .s_clk_out(s_clk_out), .s_rst_n(s_rst_n),
        .s_ctl_float(s_ctl_float), .s_adp_zero(s_adp_zero), .p_out_float(p_out_float),
        .bridge_req(bridge_req), .bridge_gnt(bridge_gnt), .bridge_park(bridge_park));

    sba_partner far (.want(want), .ext_arb(ext_arb), .gnt_w(gnt_w),
        .s_clk_in(s_clk_out[0]), .s_req_n(s_req_n), .s_frame_n(s_frame_n),
        .s_irdy_n(s_irdy_n), .p_clk_in(p_clk_in));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(negedge clk) begin
        if (!rst && gnt_w !== gnt_seen) begin
            gnt_seen = gnt_w;
            `CHK("one grant", 1'b1, $countones(~gnt_w) <= 1)
            for (int i = 0; i < NUM_EXT_REQ; i++) if (gnt_w == ~(4'h1 << i)) gnt_log.push_back(i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask

    task automatic do_reset(input logic cfn, input logic pw);
        s_cfn_n <= cfn;
        bpcc    <= pw;
        rst     <= 1'b1;
        tick(8);
        `CHK("p_out_float", 1'b1, p_out_float)
        `CHK("s_rst_n", 1'b0, s_rst_n)
        rst <= 1'b0;
        tick(40);
        `CHK("p_out_float", 1'b0, p_out_float)
    endtask

    // counts rising edges over ten pci clock periods, sampled on the quiet edge
    task automatic measure(input logic [NUM_SCLK-1:0] on);
        logic [NUM_SCLK-1:0] prev;
        int                  rises[NUM_SCLK];
        tick(8);
        @(negedge clk);
        prev = s_clk_out;
        foreach (rises[i]) rises[i] = 0;
        repeat (80) begin
            @(negedge clk);
            for (int i = 0; i < NUM_SCLK; i++) if (s_clk_out[i] && !prev[i]) rises[i]++;
            prev = s_clk_out;
        end
        for (int i = 0; i < NUM_SCLK; i++) `CHK("s_clk_out rises", on[i] ? 10 : 0, rises[i])
        `CHK("s_clk_out off", 5'h00, s_clk_out & ~on)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        ahb(1'b1, PRIO_OFS, 32'h0000_0003);
        do_reset(1'b0, 1'b0);
        ahb(1'b0, PRIO_OFS, 32'h0);
        `CHK("prio reset", PRIO_RST, rdv)
        ahb(1'b0, CTRL_OFS, 32'h0);
        `CHK("ctrl reset", CTRL_RST, rdv)
        ahb(1'b1, 8'h0c, 32'hffff_ffff);
        ahb(1'b0, 8'h0c, 32'h0);
        `CHK("unmapped", 32'h0000_0000, rdv)
        `CHK("hresp", 1'b0, hresp)
        ahb(1'b0, STATUS_OFS, 32'h0);
        `CHK("status mode", 3'h5, rdv[2:0])
        `CHK("parked pins", 4'hf, s_gnt_n)
        `CHK("bridge parked", 1'b1, bridge_gnt)
    endtask

    task automatic t_sec_reset();
        ahb(1'b1, PRIO_OFS, 32'h0000_0013);
        ahb(1'b1, CTRL_OFS, 32'h0000_0001);
        tick(4);
        `CHK("s_rst_n", 1'b0, s_rst_n)
        `CHK("s_ctl_float", 1'b1, s_ctl_float)
        `CHK("s_adp_zero", 1'b1, s_adp_zero)
        `CHK("s_gnt_oe_n", 4'hf, s_gnt_oe_n)
        ahb(1'b0, PRIO_OFS, 32'h0);
        `CHK("prio kept", 32'h0000_0013, rdv)
        ahb(1'b1, CTRL_OFS, 32'h0000_0003);
        ahb(1'b1, CTRL_OFS, 32'h0000_0002);
        tick(4);
        `CHK("s_rst_n chip", 1'b0, s_rst_n)
        ahb(1'b1, CTRL_OFS, 32'h0000_0000);
        tick(40);
        `CHK("s_rst_n", 1'b1, s_rst_n)
        `CHK("s_adp_zero", 1'b0, s_adp_zero)
    endtask

    // requester 1 high, 2 and 3 low: low group shares one slot with 1
    task automatic t_arb();
        int last;
        gnt_log.delete();
        want <= 4'he;
        for (int n = 0; n < 6000 && gnt_log.size() < 9; n++) tick(1);
        want <= 4'h0;
        `CHK("grant count", 1'b1, gnt_log.size() >= 9)
        last = 0;
        for (int k = 1; k < 9 && k < gnt_log.size(); k++) begin
            `CHK("group slot", 1'b1, (gnt_log[k] == 1) != (gnt_log[k-1] == 1))
            if (gnt_log[k] != 1) begin
                if (last != 0) `CHK("low rotation", 1'b1, gnt_log[k] != last)
                last = gnt_log[k];
            end
        end
    endtask

    task automatic t_clocks();
        ahb(1'b1, CTRL_OFS, 32'h0000_0020);
        measure(5'h1d);
        ahb(1'b1, CTRL_OFS, 32'h0000_0024);
        measure(5'h1d);
        do_reset(1'b0, 1'b1);
        ahb(1'b1, CTRL_OFS, 32'h0000_0004);
        measure(5'h00);
        ahb(1'b0, STATUS_OFS, 32'h0);
        `CHK("status b2", 1'b1, rdv[3])
        ahb(1'b1, CTRL_OFS, 32'h0000_0000);
        measure(5'h1f);
    endtask

    task automatic t_ext();
        ext_arb <= 1'b1;
        do_reset(1'b1, 1'b0);
        `CHK("ext oe", 4'he, s_gnt_oe_n)
        ahb(1'b0, STATUS_OFS, 32'h0);
        `CHK("status ext", 1'b0, rdv[2])
        want <= 4'h1;
        tick(8);
        `CHK("bridge_gnt", 1'b1, bridge_gnt)
        `CHK("bridge_park", 1'b1, bridge_park)
        `CHK("req out idle", 1'b1, s_gnt_n[0])
        bridge_req <= 1'b1;
        tick(4);
        `CHK("req out", 1'b0, s_gnt_n[0])
        `CHK("no park", 1'b0, bridge_park)
        want <= 4'h0;
        tick(8);
        `CHK("grant gone", 1'b0, bridge_gnt)
        bridge_req <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {hsel, hwrite, htrans, haddr, hsize, hwdata} = '0;
        {rst, s_cfn_n, bpcc, bridge_req, ext_arb} = 5'h10;
        {want, gnt_seen, checks, n_mismatch} = '0;
        do_reset(1'b0, 1'b0);
        t_regs();
        t_sec_reset();
        t_arb();
        t_clocks();
        t_ext();
        finish_test();
    end

    initial begin
        #200000;
        n_mismatch++;
        $display("watchdog expired");
        finish_test();
    end
endmodule
